// ---- swpc_map.vh ----
// swpc_map.vh: register offsets, field positions, reset values and timing
// counts for the sleep/wake power controller; definitions only.
`ifndef SWPC_MAP_VH
`define SWPC_MAP_VH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define SWPC_OFF_CTRL 8'h00
`define SWPC_OFF_COUNT 8'h04
`define SWPC_OFF_CMPA 8'h08
`define SWPC_OFF_CMPB 8'h0c
`define SWPC_OFF_WREC 8'h10
`define SWPC_OFF_WCORE 8'h14
`define SWPC_OFF_STAT 8'h18
`define SWPC_OFF_PDIS 8'h38
`define SWPC_OFF_SER1 8'h40
// ------------------------------------------------------------
// control fields and reset values
// ------------------------------------------------------------
`define SWPC_CTRL_DS2 0
`define SWPC_CTRL_XTAL 1
`define SWPC_CTRL_PAUSE 2
`define SWPC_CTRL_EXP_LO 4
`define SWPC_CTRL_EXP_HI 7
`define SWPC_EXP_RST 4'h1
`define SWPC_PDIS_SER1 1
`define SWPC_WCORE_BIT 0
// ------------------------------------------------------------
// wake record bit positions
// ------------------------------------------------------------
`define SWPC_WK_GPIO 0
`define SWPC_WK_SER 1
`define SWPC_WK_ROUTABLE_IRQ_INPUT_D 2
`define SWPC_WK_DBG 3
`define SWPC_WK_SYS 4
`define SWPC_WK_CMPA 5
`define SWPC_WK_CMPB 6
`define SWPC_WK_WRAP 7
`define SWPC_WK_CORE 8
`define SWPC_WK_W 9
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SWPC_CLK_MHZ 125
`define SWPC_RST_NS 64
`define SWPC_RST_CYC (`SWPC_RST_NS * `SWPC_CLK_MHZ / 1000)
`endif

// ---- swpc_top.v ----
// swpc_top.v: power state sequencer, wake recorder, 32-bit sleep timer and
// serial controller 1 clock gate.
// assumes: wfi/sleepdeep/irq come from core logic on core_clk_i; debug
// requests, pins and slow timer clocks are asynchronous and sampled here.
// Functional notes
// [RULE1] idle sleep halts execution until interrupt, no power loss, no reset
// [RULE2] deep sleep 1 removes core power, sleep timer keeps counting
// [RULE3] deep sleep 2 like 1 but timer stopped, no timer wake; here a selected crystal keeps the timer counting
// [RULE4] deep sleep 0 keeps core power, peripherals held in reset
// [RULE5] wfi with deep bit clear idles; with bit set starts deep sleep
// [RULE6] deep request waits in pre-sleep until system power-up request clears
// [RULE7] deep wake restores power, resets processor, returns to running
// [RULE8] deep 1 and 2 wake on pin, serial wake pin or irq d change
// [RULE9] deep 1 and 2 wake on debug or system power-up request set
// [RULE10] timer compare a, b and wrap wake only in deep sleep 1
// [RULE11] core wake bit write wakes only in deep sleep 0
// [RULE12] wake sources recorded always, several may be recorded
// [RULE13] sleep timer is a 32-bit counter
// [RULE14] timer clock selects khz reference or crystal, khz after reset
// [RULE15] prescaler divides source by two to the programmed exponent; an exponent of zero divides by two here
// [RULE16] two compares and wrap each raise interrupt or wake event
// [RULE17] timer runs through debug halt unless pause option set
// [RULE18] rc off and no crystal in deep sleep stops timer and its wakes
// [RULE19] serial1 gate bit stops serial controller 1 clock
// [RULE20] software gates a peripheral only once it is idle
// [RULE21] gated peripheral registers ignore writes, reads hold last value
// [RULE22] debug power-up request set forces deep sleep 0
// [RULE23] rc oscillator restarts after wake from deep sleep 2
// [RULE24] serial1 gate is read-write bit one of peripheral disable
// [RULE25] counter increments per tick, rolls over to zero, flags wrap
//
// Decided for this implementation: the address map and the plain strobed port.
`include "swpc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module swpc_top #(
  parameter GPIO_W = 16,
  parameter EXP_W = 4
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire wfi_i,
  input wire sleepdeep_i,
  input wire irq_i,
  input wire debug_halt_i,
  input wire dbg_pwrup_req_i,
  input wire sys_pwrup_req_i,
  input wire [GPIO_W-1:0] gpio_i,
  input wire serial_wake_pin_i,
  input wire routable_irq_input_d_i,
  input wire khz_reference_clock_i,
  input wire crystal_32k_clock_i,
  output reg cpu_idle_o,
  output reg core_pwr_en_o,
  output reg core_rst_n_o,
  output reg periph_rst_n_o,
  output reg low_freq_rc_osc_en_o,
  output reg serial1_clk_en_o,
  output reg [2:0] tmr_evt_o,
  output reg [31:0] sleep_count_o
);
  // ------------------------------------------------------------
  // states and sleep modes
  // ------------------------------------------------------------
  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_PRE = 3'h2;
  localparam [2:0] ST_SLEEP = 3'h3;
  localparam [2:0] ST_WAKE = 3'h4;
  localparam [1:0] MD_DS0 = 2'h0;
  localparam [1:0] MD_DS1 = 2'h1;
  localparam [1:0] MD_DS2 = 2'h2;
  localparam NS = GPIO_W + 6;
  localparam integer RST_CYC_I = `SWPC_RST_CYC;
  localparam [7:0] RST_CYC = RST_CYC_I[7:0];

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // async inputs packed into one vector: three stages, change counted
  // only when stages two and three agree, which rejects a metastable hop
  wire [NS-1:0] raw = {crystal_32k_clock_i, khz_reference_clock_i,
    sys_pwrup_req_i, dbg_pwrup_req_i, routable_irq_input_d_i,
    serial_wake_pin_i, gpio_i};
  reg [NS-1:0] sy1;
  reg [NS-1:0] sy2;
  reg [NS-1:0] sy3;
  reg [NS-1:0] stab;
  reg [NS-1:0] chg;
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi = gi + 1)
    begin : g_sync
      always @(posedge core_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          sy1[gi] <= 1'b0;
          sy2[gi] <= 1'b0;
          sy3[gi] <= 1'b0;
          stab[gi] <= 1'b0;
          chg[gi] <= 1'b0;
        end
        else
        begin
          sy1[gi] <= raw[gi];
          sy2[gi] <= sy1[gi];
          sy3[gi] <= sy2[gi];
          chg[gi] <= 1'b0;
          if (sy2[gi] == sy3[gi])
          begin
            stab[gi] <= sy3[gi];
            chg[gi] <= (sy3[gi] != stab[gi]);
          end
        end
      end
    end
  endgenerate

  wire gpio_chg = |chg[GPIO_W-1:0];
  wire ser_chg = chg[GPIO_W];
  wire routable_irq_input_d_chg = chg[GPIO_W+1];
  wire dbg_req = stab[GPIO_W+2];
  wire sys_req = stab[GPIO_W+3];
  wire dbg_set = chg[GPIO_W+2] & stab[GPIO_W+2];
  wire sys_set = chg[GPIO_W+3] & stab[GPIO_W+3];
  wire khz_rise = chg[GPIO_W+4] & stab[GPIO_W+4];
  wire xtal_rise = chg[GPIO_W+5] & stab[GPIO_W+5];

  // ------------------------------------------------------------
  // registers written by software, and controller state
  // ------------------------------------------------------------
  reg ds2_sel;
  reg xtal_sel;
  reg pause_halt;
  reg [EXP_W-1:0] exp_n;
  reg [31:0] cmpa;
  reg [31:0] cmpb;
  reg ser1_gate;
  reg [31:0] ser1_cfg;
  reg [`SWPC_WK_W-1:0] wrec;
  reg [2:0] state;
  reg [1:0] mode;
  reg [7:0] rst_cnt;
  reg [14:0] pre_cnt;
  reg [31:0] count;

  wire wr_ctrl = wr_i && (addr_i == `SWPC_OFF_CTRL);
  wire wr_wrec = wr_i && (addr_i == `SWPC_OFF_WREC);
  wire core_wr = wr_i && (addr_i == `SWPC_OFF_WCORE) && wdata_i[`SWPC_WCORE_BIT];

  // control, compare and gate registers
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ds2_sel <= 1'b0;
      xtal_sel <= 1'b0; // khz reference after reset [RULE14]
      pause_halt <= 1'b0; // keep running through a halt by default [RULE17]
      exp_n <= `SWPC_EXP_RST;
      cmpa <= 32'h0;
      cmpb <= 32'h0;
      ser1_gate <= 1'b0;
      ser1_cfg <= 32'h0;
    end
    else if (wr_i)
    begin
      if (addr_i == `SWPC_OFF_CTRL)
      begin
        ds2_sel <= wdata_i[`SWPC_CTRL_DS2];
        xtal_sel <= wdata_i[`SWPC_CTRL_XTAL]; // [RULE14]
        pause_halt <= wdata_i[`SWPC_CTRL_PAUSE];
        exp_n <= wdata_i[`SWPC_CTRL_EXP_HI:`SWPC_CTRL_EXP_LO];
      end
      else if (addr_i == `SWPC_OFF_CMPA)
        cmpa <= wdata_i;
      else if (addr_i == `SWPC_OFF_CMPB)
        cmpb <= wdata_i;
      else if (addr_i == `SWPC_OFF_PDIS)
        ser1_gate <= wdata_i[`SWPC_PDIS_SER1]; // [RULE24]
      else if (addr_i == `SWPC_OFF_SER1 && !ser1_gate)
        ser1_cfg <= wdata_i; // writes dropped while gated [RULE21]
    end
  end

  // ------------------------------------------------------------
  // sleep timer
  // ------------------------------------------------------------
  // the rc oscillator is off only in deep sleep 2; the khz reference is
  // derived from it, so only the crystal can keep the timer alive there
  wire rc_off = (state == ST_SLEEP) && (mode == MD_DS2);
  wire src_edge = xtal_sel ? xtal_rise : (khz_rise & ~rc_off); // [RULE18]
  wire tmr_run = src_edge & ~(pause_halt & debug_halt_i); // [RULE17]
  // tick when the low exp bits of the prescaler are all ones; exponent
  // zero is treated as one so the divide is never bypassed
  wire [EXP_W-1:0] exp_eff = (exp_n == {EXP_W{1'b0}}) ? {{(EXP_W-1){1'b0}}, 1'b1} : exp_n;
  wire [14:0] pmask = ~(15'h7fff << exp_eff);
  wire tick = tmr_run && ((pre_cnt & pmask) == pmask); // [RULE15]
  wire ev_cmpa = tick && (count == cmpa);
  wire ev_cmpb = tick && (count == cmpb);
  wire ev_wrap = tick && (count == 32'hffffffff);

  // prescaler and 32-bit counter
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pre_cnt <= 15'h0;
      count <= 32'h0;
    end
    else if (tmr_run)
    begin
      pre_cnt <= pre_cnt + 15'h1; // [RULE15]
      if (tick)
        count <= count + 32'h1; // wraps all ones to zero [RULE13] [RULE25]
    end
  end

  // timer event pulses usable as interrupt requests by the core
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tmr_evt_o <= 3'h0;
      sleep_count_o <= 32'h0;
    end
    else
    begin
      tmr_evt_o <= {ev_wrap, ev_cmpb, ev_cmpa}; // [RULE16]
      sleep_count_o <= count;
    end
  end

  // ------------------------------------------------------------
  // wake recording
  // ------------------------------------------------------------
  // recorded in every state, so several sources can pile up between the
  // first wake event and the core running again
  wire [`SWPC_WK_W-1:0] wk_evt = {core_wr, ev_wrap, ev_cmpb, ev_cmpa,
    sys_set, dbg_set, routable_irq_input_d_chg, ser_chg, gpio_chg}; // [RULE12]

  // write one to clear; a new event in the same cycle wins
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wrec <= {`SWPC_WK_W{1'b0}};
    else if (wr_wrec)
      wrec <= (wrec & ~wdata_i[`SWPC_WK_W-1:0]) | wk_evt; // [RULE12]
    else
      wrec <= wrec | wk_evt; // [RULE12]
  end

  // ------------------------------------------------------------
  // wake qualification per sleep mode
  // ------------------------------------------------------------
  wire true_deep = (mode == MD_DS1) || (mode == MD_DS2);
  wire wk_pins = gpio_chg | ser_chg | routable_irq_input_d_chg; // [RULE8]
  wire wk_dbg = dbg_set | sys_set; // [RULE9]
  wire wk_tmr = ev_cmpa | ev_cmpb | ev_wrap;
  wire wake = (true_deep && (wk_pins || wk_dbg)) ||
    ((mode == MD_DS1) && wk_tmr) || // [RULE10]
    ((mode == MD_DS0) && core_wr); // [RULE11]

  // ------------------------------------------------------------
  // power state machine
  // ------------------------------------------------------------
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_RUN;
      mode <= MD_DS1;
      rst_cnt <= 8'h0;
    end
    else
    begin
      case (state)
        ST_RUN:
        begin
          if (wfi_i && !sleepdeep_i)
            state <= ST_IDLE; // [RULE5]
          else if (wfi_i && sleepdeep_i)
            state <= ST_PRE; // [RULE5]
        end
        ST_IDLE:
        begin
          if (irq_i)
            state <= ST_RUN; // [RULE1]
        end
        ST_PRE:
        begin
          // hold everything powered while the debugger accesses memory
          if (!sys_req) // [RULE6]
          begin
            state <= ST_SLEEP;
            if (dbg_req)
              mode <= MD_DS0; // [RULE22]
            else if (ds2_sel)
              mode <= MD_DS2; // [RULE3]
            else
              mode <= MD_DS1; // [RULE2]
          end
        end
        ST_SLEEP:
        begin
          if (wake)
          begin
            state <= ST_WAKE; // [RULE7]
            rst_cnt <= 8'h0;
          end
        end
        ST_WAKE:
        begin
          // power is back; keep the processor in reset for a while
          if (rst_cnt == RST_CYC - 8'h1)
            state <= ST_RUN; // [RULE7]
          else
            rst_cnt <= rst_cnt + 8'h1;
        end
        default:
          state <= ST_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------
  // power, reset and clock outputs
  // ------------------------------------------------------------
  // registered from the current state and mode, the wake and the serial1 gate bit, so they follow them one cycle later
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cpu_idle_o <= 1'b0;
      core_pwr_en_o <= 1'b1;
      core_rst_n_o <= 1'b1;
      periph_rst_n_o <= 1'b1;
      low_freq_rc_osc_en_o <= 1'b1;
      serial1_clk_en_o <= 1'b1;
    end
    else
    begin
      cpu_idle_o <= (state == ST_IDLE) || (state == ST_PRE); // [RULE1]
      // deep sleep 1 and 2 drop core power; deep sleep 0 keeps it [RULE4]
      core_pwr_en_o <= !((state == ST_SLEEP) && true_deep); // [RULE2]
      // reset only once the sleep state is reached, never in pre-sleep
      core_rst_n_o <= !((state == ST_SLEEP) || (state == ST_WAKE)); // [RULE7]
      // debug and interrupt-controller logic sits outside this reset
      periph_rst_n_o <= !((state == ST_SLEEP) || (state == ST_WAKE)); // [RULE4]
      // rc comes back as soon as the wake is taken [RULE23]
      low_freq_rc_osc_en_o <= !(rc_off && !wake); // [RULE3]
      serial1_clk_en_o <= !ser1_gate; // [RULE19]
    end
  end

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  // data appear the cycle after the read strobe; unmapped reads give zero
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 32'h0;
    else if (!rd_i)
      rdata_o <= 32'h0;
    else if (addr_i == `SWPC_OFF_CTRL)
      rdata_o <= {24'h0, exp_n, 1'b0, pause_halt, xtal_sel, ds2_sel};
    else if (addr_i == `SWPC_OFF_COUNT)
      rdata_o <= count;
    else if (addr_i == `SWPC_OFF_CMPA)
      rdata_o <= cmpa;
    else if (addr_i == `SWPC_OFF_CMPB)
      rdata_o <= cmpb;
    else if (addr_i == `SWPC_OFF_WREC)
      rdata_o <= {{(32-`SWPC_WK_W){1'b0}}, wrec};
    else if (addr_i == `SWPC_OFF_STAT)
      rdata_o <= {24'h0, sys_req, dbg_req, 1'b0, mode, state};
    else if (addr_i == `SWPC_OFF_PDIS)
      rdata_o <= {30'h0, ser1_gate, 1'b0};
    else if (addr_i == `SWPC_OFF_SER1)
      rdata_o <= ser1_cfg; // frozen at gating [RULE21]
    else
      rdata_o <= 32'h0;
  end
endmodule // swpc_top
`default_nettype wire

// ---- swpc_cpu_dbg.sv ----
// swpc_cpu_dbg.sv: behavioural stand-in for the core and the debug port.
// assumes: driven by testbench tasks; shares the controller's clock.
`timescale 1ns/1ps
`default_nettype none
module swpc_cpu_dbg (
  input wire logic clk_i,
  output logic wfi_o,
  output logic deep_o,
  output logic irq_o,
  output logic dbg_req_o,
  output logic sys_req_o
);
  // ------------------------------------------------------------
  // core and debug requests
  // ------------------------------------------------------------
  // all quiet at time zero
  initial
  begin
    wfi_o = 1'b0;
    deep_o = 1'b0;
    irq_o = 1'b0;
    dbg_req_o = 1'b0;
    sys_req_o = 1'b0;
  end
  // one-cycle sleep instruction with the deep bit beside it
  task sleep(input logic deep);
    @(posedge clk_i);
    deep_o <= deep;
    wfi_o <= 1'b1;
    @(posedge clk_i);
    wfi_o <= 1'b0;
  endtask
  // interrupt after lat cycles, so answers can be prompt or slow
  task irq(input int lat);
    repeat (lat) @(posedge clk_i);
    irq_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    irq_o <= 1'b0;
  endtask
  // debug and system request levels are both driven on the next clock edge
  task reqs(input logic dbg, input logic sys);
    @(posedge clk_i);
    dbg_req_o <= dbg;
    sys_req_o <= sys;
  endtask
endmodule // swpc_cpu_dbg
`default_nettype wire

// ---- swpc_top_properties.sv ----
// swpc_top_properties.sv: concurrent checks on the controller's ports.
// assumes: bound into swpc_top; one clock, asynchronous active-low reset.
`include "swpc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module swpc_chk (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic wfi_i,
  input wire logic sleepdeep_i,
  input wire logic dbg_pwrup_req_i,
  input wire logic sys_pwrup_req_i,
  input wire logic cpu_idle_o,
  input wire logic core_pwr_en_o,
  input wire logic core_rst_n_o,
  input wire logic periph_rst_n_o,
  input wire logic low_freq_rc_osc_en_o,
  input wire logic serial1_clk_en_o,
  input wire logic [2:0] tmr_evt_o,
  input wire logic [31:0] sleep_count_o
);
  // ------------------------------------------------------------
  // helpers and properties
  // ------------------------------------------------------------
  logic [3:0] quiet_cnt;
  logic [3:0] dbg_cnt;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // settled request levels; the synchronisers hide the first cycles
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      quiet_cnt <= 4'h0;
      dbg_cnt <= 4'h0;
    end
    else
    begin
      quiet_cnt <= (dbg_pwrup_req_i | sys_pwrup_req_i) ? 4'h0 : quiet_cnt + {3'h0, quiet_cnt != 4'hf};
      dbg_cnt <= !dbg_pwrup_req_i ? 4'h0 : dbg_cnt + {3'h0, dbg_cnt != 4'hf};
    end
  end
  idle_keeps_power_a:
    assert property (wfi_i && !sleepdeep_i && !cpu_idle_o && core_rst_n_o |-> ##2
      cpu_idle_o && core_pwr_en_o && core_rst_n_o && periph_rst_n_o) else $error("idle sleep entry wrong");
  deep_powers_down_a:
    assert property (wfi_i && sleepdeep_i && !cpu_idle_o && core_rst_n_o && quiet_cnt == 4'hf |-> ##3
      !core_pwr_en_o && !core_rst_n_o && !periph_rst_n_o) else $error("deep sleep did not power down");
  pre_sleep_holds_a:
    assert property (sys_pwrup_req_i [*8] ##0 cpu_idle_o |=> core_pwr_en_o && core_rst_n_o && periph_rst_n_o)
      else $error("power removed before request cleared");
  wake_resets_core_a:
    assert property ($rose(core_pwr_en_o) |-> !core_rst_n_o [*6] ##[1:4] core_rst_n_o && core_pwr_en_o)
      else $error("wake reset cycle wrong");
  osc_only_asleep_a:
    assert property (!low_freq_rc_osc_en_o |-> !core_pwr_en_o && !core_rst_n_o) else $error("osc off while awake");
  osc_restarts_a:
    assert property ($rose(core_pwr_en_o) |-> low_freq_rc_osc_en_o) else $error("osc not restarted");
  gate_follows_bit_a:
    assert property (wr_i && addr_i == `SWPC_OFF_PDIS |-> ##2
      serial1_clk_en_o == !$past(wdata_i[`SWPC_PDIS_SER1], 2)) else $error("serial clock gate wrong");
  debug_keeps_core_a:
    assert property (dbg_cnt == 4'hf |-> core_pwr_en_o) else $error("core power lost under debug");
  timer_pulse_a:
    assert property (tmr_evt_o != 3'h0 |=> tmr_evt_o == 3'h0) else $error("timer event too long");
  count_step_a:
    assert property (sleep_count_o != $past(sleep_count_o) |-> sleep_count_o == $past(sleep_count_o) + 32'h1)
      else $error("timer count jumped");
endmodule // swpc_chk
bind swpc_top swpc_chk u_chk (.core_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .wfi_i, .sleepdeep_i,
  .dbg_pwrup_req_i, .sys_pwrup_req_i, .cpu_idle_o, .core_pwr_en_o, .core_rst_n_o, .periph_rst_n_o,
  .low_freq_rc_osc_en_o, .serial1_clk_en_o, .tmr_evt_o, .sleep_count_o);
`default_nettype wire

// ---- testbench.sv ----
// testbench.sv: self-checking run of the sleep/wake power controller.
// assumes: swpc_top, its checker and the core/debug stand-in are compiled first.
`include "swpc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ------------------------------------------------------------
  // signals, clocks and instances
  // ------------------------------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, swk = 1'b0, khz = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, d, rdata, cnt;
  logic [15:0] gpio = 16'h0;
  logic wfi, deep, irq, dbg, sys, idle, pwr, crst, prst, osc, sclk;
  logic halt = 1'b0, routable_irq_input_d = 1'b0, xtal = 1'b0, xrun = 1'b0;
  logic [2:0] evt;
  logic [31:0] exq[$], mkq[$];
  int errors = 0, comparisons = 0, cyc = 0;
  // slow reference runs on its own phase; the crystal only toggles once enabled
  initial forever #4 clk = ~clk;
  initial forever #61 khz = ~khz;
  initial forever #40 xtal = xrun ? ~xtal : xtal;
  swpc_top dut (.core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .wfi_i(wfi), .sleepdeep_i(deep), .irq_i(irq), .debug_halt_i(halt),
    .dbg_pwrup_req_i(dbg), .sys_pwrup_req_i(sys), .gpio_i(gpio), .serial_wake_pin_i(swk),
    .routable_irq_input_d_i(routable_irq_input_d), .khz_reference_clock_i(khz), .crystal_32k_clock_i(xtal),
    .cpu_idle_o(idle), .core_pwr_en_o(pwr), .core_rst_n_o(crst), .periph_rst_n_o(prst),
    .low_freq_rc_osc_en_o(osc), .serial1_clk_en_o(sclk), .tmr_evt_o(evt), .sleep_count_o(cnt));
  swpc_cpu_dbg p (.clk_i(clk), .wfi_o(wfi), .deep_o(deep), .irq_o(irq), .dbg_req_o(dbg), .sys_req_o(sys));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    if (got !== exp)
      errors++;
  endtask
  task chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
      $display("[ERR] %0t output %b expected %b", $time, got, exp);
    if (got !== exp)
      errors++;
  endtask
  task bwr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // the expectation is queued; the monitor compares when the data stand
  task brd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exq.push_back(e & m);
    mkq.push_back(m);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task waitp;
    int n;
    n = 0;
    while (pwr !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task conclude;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // read monitor and hang guard
  always @(posedge clk)
  begin
    rd_q <= rd;
    cyc <= cyc + 1;
    if (rd_q)
      cmp_rd(rdata & mkq.pop_front(), exq.pop_front());
    if (cyc == 3000)
    begin
      errors++;
      conclude;
    end
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hbecb));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    bwr(`SWPC_OFF_CMPA, 32'h3);
    d = $urandom | 32'h8000_0000;
    bwr(`SWPC_OFF_CMPB, d);
    brd(`SWPC_OFF_CMPB, d, 32'hffff_ffff);
    brd(`SWPC_OFF_CTRL, 32'h10, 32'hff);
    brd(`SWPC_OFF_PDIS, 32'h0, 32'h2);
    brd(8'h3c, 32'h0, 32'hffff_ffff);
    bwr(`SWPC_OFF_COUNT, 32'hffff_fff0);
    while (evt[0] !== 1'b1 && cyc < 900) @(posedge clk);
    chk(cnt === 32'h3, 1'b1);
    p.sleep(1'b0);
    repeat (3) @(posedge clk);
    chk(idle & pwr & crst & prst, 1'b1);
    p.irq(5);
    repeat (4) @(posedge clk);
    chk(idle, 1'b0);
    p.reqs(1'b0, 1'b1);
    repeat (8) @(posedge clk);
    p.sleep(1'b1);
    repeat (12) @(posedge clk);
    chk(idle & pwr & crst, 1'b1);
    bwr(`SWPC_OFF_WREC, 32'h1ff);
    p.reqs(1'b0, 1'b0);
    repeat (12) @(posedge clk);
    chk(pwr | crst, 1'b0);
    gpio <= gpio ^ (16'h1 << $urandom_range(15));
    swk <= ~swk;
    routable_irq_input_d <= ~routable_irq_input_d;
    waitp;
    chk(pwr, 1'b1);
    chk(crst, 1'b0);
    repeat (14) @(posedge clk);
    chk(crst & prst & ~idle, 1'b1);
    brd(`SWPC_OFF_WREC, 32'h7, 32'hff);
    bwr(`SWPC_OFF_CTRL, 32'h11);
    bwr(`SWPC_OFF_WREC, 32'h1ff);
    p.sleep(1'b1);
    repeat (6) @(posedge clk);
    chk(osc | pwr, 1'b0);
    // the reference dies with the rc oscillator, so the count must freeze
    d = cnt;
    repeat (70) @(posedge clk);
    chk(cnt === d, 1'b1);
    p.reqs(1'b0, 1'b1);
    waitp;
    chk(osc, 1'b1);
    repeat (16) @(posedge clk);
    brd(`SWPC_OFF_WREC, 32'h10, 32'h1f0);
    p.reqs(1'b1, 1'b0);
    repeat (8) @(posedge clk);
    p.sleep(1'b1);
    repeat (6) @(posedge clk);
    chk(pwr & ~prst & ~crst, 1'b1);
    bwr(`SWPC_OFF_WCORE, 32'h1);
    repeat (16) @(posedge clk);
    chk(crst & prst, 1'b1);
    brd(`SWPC_OFF_WREC, 32'h100, 32'h100);
    p.reqs(1'b0, 1'b0);
    d = $urandom;
    bwr(`SWPC_OFF_SER1, d);
    bwr(`SWPC_OFF_PDIS, 32'h2);
    repeat (2) @(posedge clk);
    chk(sclk, 1'b0);
    bwr(`SWPC_OFF_SER1, ~d);
    brd(`SWPC_OFF_SER1, d, 32'hffff_ffff);
    brd(`SWPC_OFF_PDIS, 32'h2, 32'h2);
    bwr(`SWPC_OFF_PDIS, 32'h0);
    repeat (4) @(posedge clk);
    chk(sclk, 1'b1);
    // a halt alone must not stop the timer; with the pause bit it must
    halt <= 1'b1;
    d = cnt;
    repeat (80) @(posedge clk);
    chk(cnt !== d, 1'b1);
    bwr(`SWPC_OFF_CTRL, 32'h14);
    repeat (2) @(posedge clk);
    d = cnt;
    repeat (80) @(posedge clk);
    chk(cnt === d, 1'b1);
    halt <= 1'b0;
    // crystal selected but still: the reference no longer drives the count
    bwr(`SWPC_OFF_CTRL, 32'h12);
    repeat (2) @(posedge clk);
    d = cnt;
    repeat (80) @(posedge clk);
    chk(cnt === d, 1'b1);
    xrun <= 1'b1;
    repeat (80) @(posedge clk);
    chk(cnt !== d, 1'b1);
    conclude;
  end
endmodule // testbench
`default_nettype wire
